// File: verilog/lcdc_decoder.v
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcdc_defines.vh"
// Notes on behaviour
// - On/off command bit 0 switches panel drive off (0) or on (1).
// - Start-line command loads 6-bit first displayed RAM line, 0 to 63.
// - Page command loads 4-bit page 0 to 8; shown image unaffected.
// - Page 8 is indicator row; only lowest data bit stored there.
// - Column set by two commands, high nibble and low nibble, assembled.
// - Each display-data write or parallel-mode read advances column by one, stopping at 131; page kept.
// - Busy reads high during init or reset; commands ignored meanwhile.
// - Segment-direction status bit: low reversed-column mapping, high direct mapping.
// - On/off status bit is inverse of display state.
// - Reset status bit high while initialization runs.
// - Data write stores byte at page and column, then advances column.
// - Data read returns RAM at page and column; host discards dummy read.
// - Serial interface gives no display RAM read path.
// - Segment-direction command bit selects normal or reversed column order.
// - Reverse command lights zero bits instead of one bits; RAM untouched.
// - All-on command lights every pixel, overriding reverse; RAM kept.
// - All-on while display off enters power-save instead.
// - Bias bit picks ratio, only while follower runs; ignored on fixed-bias variant.

module lcdc_decoder #(
    parameter INIT_CYC   = `LCDC_INIT_CYC,
    parameter FIXED_BIAS = 0
) (
    input  wire       clk,
    input  wire       nrst,
    input  wire       clk_en,
    input  wire       hard_reset_pin_n,
    input  wire       serial_mode,
    input  wire       follower_on,
    input  wire       cmd_data_select,
    input  wire [7:0] wr_data,
    input  wire       wr_strobe,
    input  wire       rd_strobe,
    input  wire [7:0] scan_line,
    input  wire [7:0] scan_col,
    output reg  [7:0] rd_data,
    output reg        display_on,
    output reg  [5:0] start_line,
    output reg  [3:0] page_addr,
    output reg  [7:0] col_addr,
    output reg        seg_reverse,
    output reg        invert,
    output reg        all_on,
    output reg        power_save,
    output reg        bias_sel,
    output reg        busy,
    output reg        pixel
);

    ////////////////////////////////////////////////////////////////////////
    localparam CNT_W = 16;

    function match;
        input [7:0] val;
        input [7:0] mask;
        input [7:0] op;
        begin
            match = ((val & mask) == op);
        end
    endfunction

    function [7:0] next_col;
        input [7:0] col;
        begin
            if (col >= `LCDC_LAST_COL) begin
                next_col = `LCDC_LAST_COL;
            end else begin
                next_col = col + 8'h01;
            end
        end
    endfunction

    // Display RAM: 9 pages x 132 columns, one byte per page/column
    reg  [7:0]       ram [0:9*132-1];

    // Pin reset and serial select come from outside: two-flop sync
    reg  [1:0]       rst_pin_sync;
    reg  [1:0]       ser_sync;
    reg  [CNT_W-1:0] init_cnt;
    reg              col_hi_pending;
    reg  [3:0]       col_hi;

    wire             pin_rst = ~rst_pin_sync[1];
    wire             cmd_ok  = wr_strobe & ~cmd_data_select & ~busy;
    wire [10:0]      acc_idx = page_addr * 11'd132 + {3'h0, col_addr};
    wire             page_ok = (page_addr <= `LCDC_LAST_PAGE);

    ////////////////////////////////////////////////////////////////////////
    // Pin sync starts at the released level so reset release looks quiet
    always @(posedge clk) begin
        if (!nrst) begin
            rst_pin_sync <= 2'h3;
        end else if (clk_en) begin
            rst_pin_sync <= {rst_pin_sync[0], hard_reset_pin_n};
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            ser_sync <= 2'h0;
        end else if (clk_en) begin
            ser_sync <= {ser_sync[0], serial_mode};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy/reset status held for INIT_CYC after any reset source
    reg  [CNT_W-1:0] next_init_cnt;
    reg              next_busy;

    // Pin reset reloads the count, so busy spans the whole pulse
    always @* begin
        next_init_cnt = init_cnt;
        next_busy     = busy;
        if (pin_rst) begin
            next_init_cnt = INIT_CYC[CNT_W-1:0];
            next_busy     = 1'b1;
        end else if (init_cnt != {CNT_W{1'b0}}) begin
            next_init_cnt = init_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            next_busy     = 1'b1;
        end else begin
            next_busy     = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            init_cnt <= INIT_CYC[CNT_W-1:0];
            busy     <= 1'b1;
        end else if (clk_en) begin
            init_cnt <= next_init_cnt;
            busy     <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode, one line per opcode; masks keep operand bits out
    wire             dec_onoff  = match(wr_data, `LCDC_MASK_BIT,    `LCDC_OP_ONOFF);
    wire             dec_start  = match(wr_data, `LCDC_MASK_START,  `LCDC_OP_START);
    wire             dec_page   = match(wr_data, `LCDC_MASK_NIBBLE, `LCDC_OP_PAGE);
    wire             dec_colhi  = match(wr_data, `LCDC_MASK_NIBBLE, `LCDC_OP_COLHI);
    wire             dec_collo  = match(wr_data, `LCDC_MASK_NIBBLE, `LCDC_OP_COLLO);
    wire             dec_segdir = match(wr_data, `LCDC_MASK_BIT,    `LCDC_OP_SEGDIR);
    wire             dec_rev    = match(wr_data, `LCDC_MASK_BIT,    `LCDC_OP_REVERSE);
    wire             dec_allon  = match(wr_data, `LCDC_MASK_BIT,    `LCDC_OP_ALLON);
    wire             dec_bias   = match(wr_data, `LCDC_MASK_BIT,    `LCDC_OP_BIAS);
    wire [7:0]       col_join   = {col_hi, wr_data[3:0]};
    // Pages above 8 and columns above 131 do not exist; old value stays
    wire             page_fits  = (wr_data[3:0] <= `LCDC_LAST_PAGE);
    wire             col_fits   = (col_join <= `LCDC_LAST_COL);
    wire             bias_ok    = follower_on && (FIXED_BIAS == 0);
    // A serial host has no read path, so its reads must not step the column
    wire             data_step  = cmd_data_select && !busy && page_ok &&
                                  (wr_strobe || (rd_strobe && !ser_sync[1]));

    // Next-state values; commands are dropped while busy
    reg              next_display_on;
    reg  [5:0]       next_start_line;
    reg  [3:0]       next_page_addr;
    reg  [7:0]       next_col_addr;
    reg              next_seg_reverse;
    reg              next_invert;
    reg              next_all_on;
    reg              next_power_save;
    reg              next_bias_sel;
    reg              next_col_hi_pending;
    reg  [3:0]       next_col_hi;

    always @* begin
        next_display_on     = display_on;
        next_start_line     = start_line;
        next_page_addr      = page_addr;
        next_col_addr       = col_addr;
        next_seg_reverse    = seg_reverse;
        next_invert         = invert;
        next_all_on         = all_on;
        next_power_save     = power_save;
        next_bias_sel       = bias_sel;
        next_col_hi_pending = col_hi_pending;
        next_col_hi         = col_hi;
        if (pin_rst) begin
            next_display_on     = 1'b0;
            next_start_line     = 6'h00;
            next_page_addr      = 4'h0;
            next_col_addr       = 8'h00;
            next_seg_reverse    = 1'b0;
            next_invert         = 1'b0;
            next_all_on         = 1'b0;
            next_power_save     = 1'b0;
            next_bias_sel       = 1'b0;
            next_col_hi_pending = 1'b0;
        end else if (cmd_ok) begin
            if (dec_onoff) begin
                next_display_on = wr_data[0];
                if (wr_data[0]) begin
                    next_power_save = 1'b0;
                end
            end else if (dec_start) begin
                next_start_line = wr_data[5:0];
            end else if (dec_page) begin
                if (page_fits) begin
                    next_page_addr = wr_data[3:0];
                end
            end else if (dec_colhi) begin
                next_col_hi         = wr_data[3:0];
                next_col_hi_pending = 1'b1;
            end else if (dec_collo) begin
                // Low nibble alone combines with the last high nibble
                if (col_fits) begin
                    next_col_addr = col_join;
                end
                next_col_hi_pending = 1'b0;
            end else if (dec_segdir) begin
                next_seg_reverse = wr_data[0];
            end else if (dec_rev) begin
                next_invert = wr_data[0];
            end else if (dec_allon) begin
                next_all_on = wr_data[0];
                if (wr_data[0] && !display_on) begin
                    next_power_save = 1'b1;
                end
            end else if (dec_bias) begin
                if (bias_ok) begin
                    next_bias_sel = wr_data[0];
                end
            end
        end else if (data_step) begin
            next_col_addr = next_col(col_addr);
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            display_on     <= 1'b0;
            start_line     <= 6'h00;
            page_addr      <= 4'h0;
            col_addr       <= 8'h00;
            seg_reverse    <= 1'b0;
            invert         <= 1'b0;
            all_on         <= 1'b0;
            power_save     <= 1'b0;
            bias_sel       <= 1'b0;
            col_hi_pending <= 1'b0;
            col_hi         <= 4'h0;
        end else if (clk_en) begin
            display_on     <= next_display_on;
            start_line     <= next_start_line;
            page_addr      <= next_page_addr;
            col_addr       <= next_col_addr;
            seg_reverse    <= next_seg_reverse;
            invert         <= next_invert;
            all_on         <= next_all_on;
            power_save     <= next_power_save;
            bias_sel       <= next_bias_sel;
            col_hi_pending <= next_col_hi_pending;
            col_hi         <= next_col_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM write and host read port
    always @(posedge clk) begin
        if (clk_en && nrst && !pin_rst && !busy && cmd_data_select && wr_strobe && page_ok) begin
            if (page_addr == `LCDC_IND_PAGE) begin
                ram[acc_idx] <= {7'h00, wr_data[0]};
            end else begin
                ram[acc_idx] <= wr_data;
            end
        end
    end

    // Status bits placed by name; the reset bit mirrors busy
    reg  [7:0]       status_byte;
    reg  [7:0]       next_rd_data;

    always @* begin
        status_byte                  = 8'h00;
        status_byte[`LCDC_ST_BUSY]   = busy;
        status_byte[`LCDC_ST_SEGDIR] = seg_reverse;
        status_byte[`LCDC_ST_ONOFF]  = ~display_on;
        status_byte[`LCDC_ST_RESET]  = busy;
    end

    // Read data stand from the cycle after the strobe until the next read
    always @* begin
        next_rd_data = rd_data;
        if (rd_strobe) begin
            if (!cmd_data_select) begin
                next_rd_data = status_byte;
            end else if (ser_sync[1] || !page_ok) begin
                next_rd_data = 8'h00;
            end else begin
                next_rd_data = ram[acc_idx];
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan pixel from RAM; page address never involved
    wire [5:0]  row      = start_line + scan_line[5:0];
    wire [7:0]  phys_col = seg_reverse ? scan_col : (`LCDC_LAST_COL - scan_col);
    wire [10:0] scan_idx = {8'h00, row[5:3]} * 11'd132 + {3'h0, phys_col};
    wire [7:0]  scan_byte = ram[scan_idx];

    reg              next_pixel;

    // Blank panel beats all-on, and all-on beats reverse
    always @* begin
        if (!display_on || power_save) begin
            next_pixel = 1'b0;
        end else if (all_on) begin
            next_pixel = 1'b1;
        end else begin
            next_pixel = scan_byte[row[2:0]] ^ invert;
        end
    end

    // One cycle of latency against the scan position
    always @(posedge clk) begin
        if (!nrst) begin
            pixel <= 1'b0;
        end else if (clk_en) begin
            pixel <= next_pixel;
        end
    end

endmodule // lcdc_decoder

// File: inc/lcdc_defines.vh
`ifndef LCDC_DEFINES_VH
`define LCDC_DEFINES_VH

// Command opcodes (upper bits compared under mask)
`define LCDC_OP_ONOFF      8'hae
`define LCDC_OP_START      8'h40
`define LCDC_OP_PAGE       8'hb0
`define LCDC_OP_COLHI      8'h10
`define LCDC_OP_COLLO      8'h00
`define LCDC_OP_SEGDIR     8'ha0
`define LCDC_OP_REVERSE    8'ha6
`define LCDC_OP_ALLON      8'ha4
`define LCDC_OP_BIAS       8'ha2
`define LCDC_MASK_BIT      8'hfe
`define LCDC_MASK_START    8'hc0
`define LCDC_MASK_NIBBLE   8'hf0

// Address limits
`define LCDC_LAST_COL      8'h83
`define LCDC_IND_PAGE      4'h8
`define LCDC_LAST_PAGE     4'h8

// Status bit positions
`define LCDC_ST_BUSY       7
`define LCDC_ST_SEGDIR     6
`define LCDC_ST_ONOFF      5
`define LCDC_ST_RESET      4

// Initialization time after reset, in ns, and derived cycle count
`define LCDC_INIT_NS       100
`define LCDC_CLK_NS        10
`define LCDC_INIT_CYC      ((`LCDC_INIT_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)

`endif

// File: dv/lcdc_properties.sv
`timescale 1ns/1ps
module lcdc_checker (
    input wire       clk, nrst, clk_en, serial_mode, cmd_data_select, wr_strobe, rd_strobe,
    input wire       display_on, seg_reverse, power_save, busy, hard_reset_pin_n,
    input wire [7:0] wr_data, rd_data, col_addr,
    input wire [5:0] start_line,
    input wire [3:0] page_addr
);
    wire cw = wr_strobe && clk_en && !busy && !cmd_data_select;
    wire dw = wr_strobe && clk_en && !busy && cmd_data_select;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    a_onoff_cmd: assert property (cw && (wr_data & 8'hfe) == 8'hae |=> display_on == $past(wr_data[0]))
        else $error("display on/off not taken");
    a_start_line: assert property (cw && wr_data[7:6] == 2'b01 |=> start_line == $past(wr_data[5:0]))
        else $error("start line not loaded");
    a_page_load: assert property (cw && wr_data[7:4] == 4'hb && wr_data[3:0] <= 4'h8 ##1 1 |-> page_addr == $past(wr_data[3:0]))
        else $error("page not loaded");
    a_col_step: assert property (dw && col_addr < 8'h83 |=> col_addr == $past(col_addr) + 8'h01 && $stable(page_addr))
        else $error("column did not advance");
    a_col_hold: assert property (dw && col_addr == 8'h83 |=> col_addr == 8'h83)
        else $error("column passed the last one");
    // Pin reset re-clears state, so only look once the pin has been quiet a while
    a_busy_ignore: assert property (busy && wr_strobe && hard_reset_pin_n && $past(hard_reset_pin_n, 4)
        |=> $stable(start_line) && $stable(page_addr) && $stable(display_on))
        else $error("command taken while busy");
    a_status_fmt: assert property (rd_strobe && clk_en && !cmd_data_select
        |=> rd_data == {$past(busy), $past(seg_reverse), !$past(display_on), $past(busy), 4'h0})
        else $error("status byte wrong");
    a_serial_noread: assert property (rd_strobe && clk_en && !busy && cmd_data_select && serial_mode && $past(serial_mode, 3)
        |=> rd_data == 8'h00 && $stable(col_addr))
        else $error("serial read returned data");
    a_power_save: assert property (cw && wr_data == 8'ha5 && !display_on |=> power_save)
        else $error("power save not entered");
    c_save: cover property (cw && wr_data == 8'ha5 && !display_on);
    c_sat: cover property (dw && col_addr == 8'h83);
    c_ser: cover property (rd_strobe && cmd_data_select && serial_mode);
endmodule // lcdc_checker
bind lcdc_decoder lcdc_checker u_lcdc_checker (.clk(clk), .nrst(nrst), .clk_en(clk_en), .serial_mode(serial_mode),
    .cmd_data_select(cmd_data_select), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .display_on(display_on),
    .seg_reverse(seg_reverse), .power_save(power_save), .busy(busy), .hard_reset_pin_n(hard_reset_pin_n),
    .wr_data(wr_data), .rd_data(rd_data), .col_addr(col_addr), .start_line(start_line), .page_addr(page_addr));

// File: dv/lcdc_host.sv
`timescale 1ns/1ps
module lcdc_host (
    input  wire       clk,
    output reg        cds,
    output reg  [7:0] wd,
    output reg        ws,
    output reg        rs
);
    initial begin
        cds = 1'b0;
        wd = 8'h00;
        ws = 1'b0;
        rs = 1'b0;
    end
    // Data inverted after release so a stale byte never looks valid
    task automatic xfer(input logic w, input logic sel, input logic [7:0] d);
        @(posedge clk);
        cds <= sel;
        wd <= d; // byte handed over whole on the parallel wd bus, in serial mode too
        ws <= w;
        rs <= !w;
        @(posedge clk);
        ws <= 1'b0;
        rs <= 1'b0;
        wd <= ~d;
        #1;
    endtask
endmodule // lcdc_host

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, pin_n = 1'b1, ser = 1'b0, fol = 1'b1, rd_d = 1'b0;
    logic [7:0] sl = 8'h00, sc = 8'h00, v;
    logic [7:0] d [3];
    logic [7:0] ops [5] = '{8'hae, 8'ha0, 8'ha6, 8'ha4, 8'ha2};
    logic [4:0] ev = 5'h00;
    logic [8:0] e;
    logic [8:0] exp_q [$];
    wire cds, ws, rs, disp, segr, inv, allon, psave, bias, busy, pix;
    wire [7:0] wd, rdd, col;
    wire [5:0] sline;
    wire [3:0] page;
    int n_errors = 0, samples_checked = 0, i, k;
    always #5 clk = ~clk;
    always @(posedge clk) {sl, sc} <= $urandom;
    lcdc_host u_lcdc_host (.clk(clk), .cds(cds), .wd(wd), .ws(ws), .rs(rs));
    lcdc_decoder u_lcdc_decoder (.clk(clk), .nrst(nrst), .clk_en(1'b1), .hard_reset_pin_n(pin_n), .serial_mode(ser),
        .follower_on(fol), .cmd_data_select(cds), .wr_data(wd), .wr_strobe(ws), .rd_strobe(rs), .scan_line(sl),
        .scan_col(sc), .rd_data(rdd), .display_on(disp), .start_line(sline), .page_addr(page), .col_addr(col),
        .seg_reverse(segr), .invert(inv), .all_on(allon), .power_save(psave), .bias_sel(bias), .busy(busy), .pixel(pix));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, ex, got);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c); u_lcdc_host.xfer(1'b1, 1'b0, c); endtask
    task automatic setcol(input logic [7:0] c); cmd({4'h1, c[7:4]}); cmd({4'h0, c[3:0]}); endtask
    // Bit 8 set marks the dummy read the host must throw away
    task automatic rd(input logic sel, input logic [8:0] x); exp_q.push_back(x); u_lcdc_host.xfer(1'b0, sel, 8'h00); endtask
    task automatic idle; for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clk); endtask
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (!e[8]) chk("rd_data", e[7:0], rdd);
        end
        rd_d <= rs;
    end
    initial begin
        #200us;
        n_errors++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        i = $urandom(4015);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        cmd(8'h7f);
        idle;
        chk("start_line", 8'h00, {2'b00, sline});
        rd(1'b0, 9'h020);
        for (i = 1; i >= 0; i--) begin
            for (k = 0; k < 5; k++) begin
                cmd(ops[k] | i[7:0]);
                ev[4 - k] = i[0];
                chk("mode", {3'b000, ev}, {3'b000, disp, segr, inv, allon, bias});
            end
            if (i == 1) rd(1'b0, 9'h040);
            if (i == 1) chk("pixel", 8'h01, {7'h00, pix});
        end
        cmd(8'ha5);
        chk("power_save", 8'h01, {7'h00, psave});
        @(posedge clk) fol <= 1'b0;
        cmd(8'ha3);
        chk("bias_sel", 8'h00, {7'h00, bias});
        foreach (d[k]) begin
            v = (k == 2) ? $urandom_range(63) : 8'(k * 63);
            cmd(8'h40 | v);
            chk("start_line", v, {2'b00, sline});
        end
        v = $urandom_range(131);
        setcol(v);
        chk("col_addr", v, col);
        cmd(8'hb3);
        cmd(8'hb9);
        setcol(8'd130);
        foreach (d[k]) begin
            d[k] = $urandom;
            u_lcdc_host.xfer(1'b1, 1'b1, d[k]);
        end
        chk("col_addr", 8'd131, col);
        chk("page_addr", 8'h03, {4'h0, page});
        setcol(8'd130);
        rd(1'b1, 9'h100);
        rd(1'b1, {1'b0, d[2]});
        cmd(8'hb8);
        setcol(8'd5);
        u_lcdc_host.xfer(1'b1, 1'b1, 8'hff);
        u_lcdc_host.xfer(1'b1, 1'b1, 8'hff);
        setcol(8'd5);
        rd(1'b1, 9'h100);
        rd(1'b1, 9'h001);
        @(posedge clk) ser <= 1'b1;
        repeat (3) @(posedge clk);
        rd(1'b1, 9'h000);
        @(posedge clk) pin_n <= 1'b0;
        repeat (3) @(posedge clk);
        pin_n <= 1'b1;
        rd(1'b0, 9'h0b0);
        idle;
        chk("start_line", 8'h00, {2'b00, sline});
        chk("page_addr", 8'h00, {4'h0, page});
        repeat (2) @(posedge clk);
        final_report;
    end
endmodule // tb_top
